// ---- common/ldc_pkg.sv ----
`default_nettype none
package ldc_pkg;
  localparam logic [6:0] ADDR_TX_CTRL = 7'h05;
  localparam logic [6:0] ADDR_HARD_ST = 7'h06;
  localparam logic [6:0] ADDR_SOFT_ST = 7'h07;
  localparam logic [6:0] ADDR_BIAS = 7'h08;
  localparam logic [6:0] ADDR_MOD = 7'h09;
  localparam logic [6:0] ADDR_MOD_CEIL = 7'h0a;
  localparam logic [6:0] ADDR_BIAS_CEIL = 7'h0b;
  localparam logic [6:0] ADDR_MOD_STEP = 7'h0c;
  localparam logic [6:0] ADDR_BIAS_STEP = 7'h0d;
  localparam logic [6:0] ADDR_MODE = 7'h0e;
  localparam logic [6:0] ADDR_FMASK = 7'h0f;
  localparam logic [6:0] ADDR_DEEMPH = 7'h10;
  localparam logic [6:0] ADDR_EQ = 7'h11;
  localparam logic [7:0] SETUP_KEY = 8'h12;
  localparam int TXEN_BIT = 0;
  localparam int POL_BIT = 1;
  localparam int SRES_BIT = 2;
  localparam int DEM_LO = 3;
  localparam int SIGDET_BIT = 5;
  localparam int BIAS_CLAMP_BIT = 0;
  localparam int MOD_CLAMP_BIT = 1;
  localparam logic [7:0] TX_CTRL_RST = 8'h02;
  localparam logic [8:0] BIAS_RST = 9'h010;
  localparam logic [8:0] MOD_RST = 9'h010;
  localparam logic [7:0] CEIL_RST = 8'hff;
  localparam logic [7:0] FMASK_RST = 8'h00;
  localparam logic [7:0] DEEMPH_RST = 8'h00;
  localparam logic [1:0] EQ_RST = 2'h0;
  localparam logic [4:0] FRAME_BITS = 5'h10;
  localparam logic [4:0] ADDR_BITS = 5'h08;
endpackage
`default_nettype wire

// ---- sim/ldc_host.sv ----
`default_nettype none
module ldc_host (
  output logic ser_clk,
  output logic chip_select_pin,
  output logic sda,
  input wire logic sda_line
);
  timeunit 1ns;
  timeprecision 1ns;
  // clock stands still between frames; sda idles at the pull-up level
  logic [7:0] rd_byte;
  initial begin
    rd_byte = 8'h00;
    ser_clk = 1'b0;
    chip_select_pin = 1'b0;
    sda = 1'b1;
  end
  task automatic frame(input logic [6:0] a, input logic rnw,
                       input logic [7:0] d);
    logic [15:0] w;
    w = {a, rnw, d};
    #7 chip_select_pin = 1'b1;
    for (int i = 15; i >= 0; i--) begin
      // line released after rnw on reads, device bits taken on rising
      sda = (rnw && i < 8) ? 1'b1 : w[i];
      #15 ser_clk = 1'b1;
      if (i < 8) rd_byte[i] = sda_line;
      #15 ser_clk = 1'b0;
    end
    #15 chip_select_pin = 1'b0;
    sda = 1'b1;
  endtask
endmodule
`default_nettype wire

// ---- sim/tb_laser_driver_control_logic.sv ----
`default_nettype none
module tb_laser_driver_control_logic;
  import ldc_pkg::*;
  timeunit 1ns;
  timeprecision 1ns;
  logic sys_clk = 1'b0, rst_n = 1'b1, shutdown_pin = 1'b0;
  logic [7:0] soft_exp;
  localparam logic [30:0] RST_V = {EQ_RST, 2'h0, DEEMPH_RST, BIAS_RST,
                                   MOD_RST, 1'b0};
  logic signal_present = 1'b0;
  logic [1:0] addr_level_pin = 2'h0;
  logic [7:0] hard_fault_in = 8'h00, soft_fault_in = 8'h00;
  wire logic ser_clk, chip_select_pin, host_sda;
  logic sda_out, sda_oe_n, fault_out, drive_enable, invert_path;
  logic [1:0] input_eq_setting, deemph_mode;
  logic [7:0] deemph_level, ceil_b, ceil_m;
  logic [8:0] bias_level, mod_level;
  // open-drain wire: either party pulls low
  wire logic sda_in = host_sda & (sda_oe_n | sda_out);
  int err_total = 0, compares = 0;
  logic [30:0] q[$];
  logic [30:0] exp_v, pv, last_v;
  always #50 sys_clk = ~sys_clk;
  ldc_core i_dut (.sys_clk, .rst_n, .ser_clk, .chip_select_pin, .sda_in,
    .sda_out, .sda_oe_n, .addr_level_pin, .shutdown_pin, .signal_present,
    .hard_fault_in, .soft_fault_in, .fault_out, .drive_enable,
    .invert_path, .input_eq_setting, .deemph_mode, .deemph_level,
    .bias_level, .mod_level);
  ldc_host i_host (.ser_clk, .chip_select_pin, .sda(host_sda),
    .sda_line(sda_in));
  function automatic logic [30:0] obs();
    return {input_eq_setting, deemph_mode, deemph_level, bias_level,
            mod_level, invert_path};
  endfunction
  task automatic chk(input logic [30:0] seen, input logic [30:0] want);
    compares++;
    if (seen !== want) begin
      err_total++;
      $display("BAD %0t seen %h want %h", $time, seen, want);
    end
  endtask
  task automatic stop_test();
    $display("errors %0d compares %0d", err_total, compares);
    if (err_total == 0 && compares > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  task automatic pause();
    repeat (10) @(posedge sys_clk);
    @(negedge sys_clk);
  endtask
  task automatic rd(input logic [6:0] a, input logic [7:0] want);
    i_host.frame({addr_level_pin, a[4:0]}, 1'b1, 8'hff);
    pause();
    chk(31'(i_host.rd_byte), 31'(want));
  endtask
  // exp_v is updated by the caller before the write goes out
  task automatic wr(input logic [6:0] a, input logic [7:0] d,
                    input logic su);
    if (su) begin
      i_host.frame({addr_level_pin, ADDR_MODE[4:0]}, 1'b0, SETUP_KEY);
      pause();
    end
    if (exp_v !== pv) q.push_back(exp_v);
    pv = exp_v;
    i_host.frame({addr_level_pin, a[4:0]}, 1'b0, d);
    pause();
  endtask
  task automatic step(input bit m, input logic [4:0] inc);
    int v;
    int c;
    v = int'(m ? exp_v[9:1] : exp_v[18:10]) + int'($signed(inc));
    c = int'(m ? ceil_m : ceil_b);
    if (v < 0) v = 0;
    if (v / 2 > c) begin
      v = c * 2 + v % 2;
      soft_exp[m ? MOD_CLAMP_BIT : BIAS_CLAMP_BIT] = 1'b1;
    end
    if (m) exp_v[9:1] = 9'(v);
    else exp_v[18:10] = 9'(v);
    wr(m ? ADDR_MOD_STEP : ADDR_BIAS_STEP, {3'h0, inc}, 1'b0);
  endtask
  // result watcher: any visible change consumes the oldest note
  always @(negedge sys_clk) begin
    if (rst_n && obs() !== last_v) begin
      last_v = obs();
      if (q.size() == 0) chk(last_v, ~last_v);
      else chk(last_v, q.pop_front());
    end
  end
  initial begin
    #1000000;
    err_total++;
    stop_test();
  end
  initial begin
    void'($urandom(34));
    rst_n <= 1'b0;
    exp_v = RST_V;
    pv = exp_v;
    last_v = exp_v;
    soft_exp = 8'h00;
    ceil_b = CEIL_RST;
    ceil_m = CEIL_RST;
    repeat (3) @(posedge sys_clk);
    rst_n <= 1'b1;
    @(negedge sys_clk);
    chk(obs(), exp_v);
    chk({fault_out, drive_enable}, 31'h0);
    wr(ADDR_BIAS, 8'h40, 1'b0);
    ceil_b = 8'h28;
    wr(ADDR_BIAS_CEIL, ceil_b, 1'b1);
    ceil_m = 8'h30;
    wr(ADDR_MOD_CEIL, ceil_m, 1'b1);
    exp_v[18:10] = {8'h20, 1'b0};
    wr(ADDR_BIAS, 8'h20, 1'b1);
    exp_v[9:1] = {8'h2c, 1'b0};
    wr(ADDR_MOD, 8'h2c, 1'b1);
    for (int i = 0; i < 24; i++) begin
      @(posedge sys_clk) addr_level_pin <= 2'(i);
      @(posedge sys_clk);
      i_host.frame({~addr_level_pin, ADDR_BIAS_STEP[4:0]}, 1'b0, 8'h0f);
      pause();
      step(i[0], 5'($urandom));
    end
    for (int k = 0; k < 6; k++) step(1'b0, 5'h0f);
    for (int k = 0; k < 8; k++) step(1'b1, 5'h10);
    rd(ADDR_SOFT_ST, soft_exp);
    for (int k = 0; k < 3; k++) begin
      exp_v[30:29] = (k == 2) ? 2'h3 : 2'(k);
      wr(ADDR_EQ, {6'h0, exp_v[30:29]}, 1'b1);
    end
    exp_v[26:19] = 8'h5a;
    wr(ADDR_DEEMPH, 8'h5a, 1'b1);
    for (int m = 0; m < 4; m++) begin
      exp_v[28:27] = 2'(m);
      exp_v[0] = m[0];
      wr(ADDR_TX_CTRL, {3'h0, 2'(m), 1'b0, ~m[0], 1'b1}, 1'b1);
      chk(drive_enable, 31'h1);
    end
    @(posedge sys_clk) soft_fault_in <= 8'h01;
    signal_present <= 1'b1;
    pause();
    chk({fault_out, drive_enable}, 31'h1);
    @(posedge sys_clk) soft_fault_in <= 8'h00;
    hard_fault_in <= 8'h01;
    pause();
    @(posedge sys_clk) hard_fault_in <= 8'h00;
    pause();
    chk({fault_out, drive_enable}, 31'h2);
    rd(ADDR_HARD_ST, 8'h21);
    @(posedge sys_clk) shutdown_pin <= 1'b1;
    pause();
    chk({fault_out, drive_enable}, 31'h0);
    @(posedge sys_clk) shutdown_pin <= 1'b0;
    pause();
    chk({fault_out, drive_enable}, 31'h1);
    rd(ADDR_HARD_ST, 8'h20);
    exp_v = RST_V;
    wr(ADDR_TX_CTRL, 8'h06, 1'b1);
    chk({fault_out, drive_enable}, 31'h0);
    chk(31'(q.size()), 31'h0);
    stop_test();
  end
endmodule
`default_nettype wire

// ---- src/ldc_core.sv ----
`default_nettype none
module ldc_core
  import ldc_pkg::*;
(
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic ser_clk,
  input wire logic chip_select_pin,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe_n,
  input wire logic [1:0] addr_level_pin,
  input wire logic shutdown_pin,
  input wire logic signal_present,
  input wire logic [7:0] hard_fault_in,
  input wire logic [7:0] soft_fault_in,
  output logic fault_out,
  output logic drive_enable,
  output logic invert_path,
  output logic [1:0] input_eq_setting,
  output logic [1:0] deemph_mode,
  output logic [7:0] deemph_level,
  output logic [8:0] bias_level,
  output logic [8:0] mod_level
);
  // link domain: shifter on ser_clk, cleared while chip select is low
  typedef struct packed {
    logic [4:0] cnt;
    logic [15:0] sh;
  } ldc_link_t;
  // word and toggle must outlive the frame, so only rst_n clears them
  typedef struct packed {
    logic tgl;
    logic [14:0] word;
  } ldc_hold_t;
  typedef struct packed {
    logic drv;
    logic [2:0] idx;
    logic bit_out;
  } ldc_rd_t;
  ldc_link_t lk, next_lk;
  ldc_hold_t hd, next_hd;
  ldc_rd_t rd, next_rd;
  logic [7:0] rd_hold;
  logic cs_n_rst;
  assign cs_n_rst = rst_n & chip_select_pin;

  always_comb begin
    next_lk = lk;
    next_hd = hd;
    if (lk.cnt != FRAME_BITS) begin
      next_lk.sh = {lk.sh[14:0], sda_in};
      next_lk.cnt = lk.cnt + 5'h01;
      if (lk.cnt == FRAME_BITS - 5'h01 && !lk.sh[7]) begin
        next_hd.word = {lk.sh[14:8], lk.sh[6:0], sda_in};
        next_hd.tgl = ~hd.tgl;
      end
    end
  end

  always_ff @(posedge ser_clk or negedge cs_n_rst) begin
    if (!cs_n_rst) begin
      lk <= '0;
    end else begin
      lk <= next_lk;
    end
  end
  always_ff @(posedge ser_clk or negedge rst_n) begin
    if (!rst_n) begin
      hd <= '0;
    end else begin
      hd <= next_hd;
    end
  end

  // system domain state
  typedef struct packed {
    logic [2:0] tsync;
    logic [1:0] dsync;
    logic [1:0] ssync;
    logic [1:0] selpre;
    logic [7:0] hpre;
    logic [7:0] fpre;
    logic [7:0] hsync;
    logic [7:0] fsync;
    logic [7:0] tx_ctrl;
    logic [7:0] hard_st;
    logic [7:0] soft_st;
    logic [8:0] bias;
    logic [8:0] mod;
    logic [7:0] bias_ceil;
    logic [7:0] mod_ceil;
    logic [7:0] fmask;
    logic [7:0] deemph;
    logic [1:0] eq;
    logic setup;
    logic [1:0] sel;
    logic fault;
    logic shut_d;
  } ldc_sys_t;
  ldc_sys_t s, next_s;

  function automatic logic [8:0] ldc_step(input logic [8:0] cur,
                                          input logic [4:0] inc,
                                          input logic [7:0] ceil,
                                          output logic clamp);
    logic signed [10:0] sum;
    sum = $signed({2'b00, cur}) + $signed({{6{inc[4]}}, inc});
    clamp = 1'b0;
    if (sum < 0) begin
      ldc_step = 9'h000;
    end else if (sum[9:1] > {1'b0, ceil}) begin
      ldc_step = {ceil, sum[0]};
      clamp = 1'b1;
    end else begin
      ldc_step = sum[8:0];
    end
  endfunction

  logic [6:0] w_addr;
  logic [7:0] w_data;
  logic w_stb, sel_ok, wr_ok, cb, cm;
  logic [8:0] nb, nm;
  logic [7:0] hard_raw;
  always_comb begin
    next_s = s;
    w_addr = hd.word[14:8];
    w_data = hd.word[7:0];
    w_stb = s.tsync[2] ^ s.tsync[1];
    sel_ok = w_addr[6:5] == s.sel;
    nb = ldc_step(s.bias, w_data[4:0], s.bias_ceil, cb);
    nm = ldc_step(s.mod, w_data[4:0], s.mod_ceil, cm);
    next_s.tsync = {s.tsync[1:0], hd.tgl};
    next_s.dsync = {s.dsync[0], shutdown_pin};
    next_s.ssync = {s.ssync[0], signal_present};
    next_s.hpre = hard_fault_in;
    next_s.hsync = s.hpre;
    next_s.fpre = soft_fault_in;
    next_s.fsync = s.fpre;
    next_s.selpre = addr_level_pin;
    next_s.sel = s.selpre;
    next_s.shut_d = s.dsync[1];
    hard_raw = s.hsync & ~s.fmask;
    next_s.hard_st = s.hard_st | hard_raw;
    next_s.hard_st[SIGDET_BIT] = s.ssync[1];
    next_s.soft_st = s.soft_st | s.fsync;
    if (|hard_raw) next_s.fault = 1'b1;
    if (s.shut_d != s.dsync[1]) begin
      next_s.fault = |hard_raw; // set wins
      next_s.hard_st = hard_raw;
      next_s.hard_st[SIGDET_BIT] = s.ssync[1];
      next_s.soft_st = s.fsync;
    end
    wr_ok = w_stb && sel_ok;
    if (wr_ok) begin
      next_s.setup = 1'b0;
      if (w_addr[4:0] == ADDR_MOD_STEP[4:0]) begin
        next_s.mod = nm;
        if (cm) next_s.soft_st[MOD_CLAMP_BIT] = 1'b1;
      end else if (w_addr[4:0] == ADDR_BIAS_STEP[4:0]) begin
        next_s.bias = nb;
        if (cb) next_s.soft_st[BIAS_CLAMP_BIT] = 1'b1;
      end else if (w_addr[4:0] == ADDR_MODE[4:0] && w_data == SETUP_KEY) begin
        next_s.setup = 1'b1;
      end else if (s.setup) begin
        if (w_addr[4:0] == ADDR_TX_CTRL[4:0]) begin
          next_s.tx_ctrl = w_data;
          if (w_data[SRES_BIT] && w_data[1:0] == 2'b10) begin
            next_s.tx_ctrl = TX_CTRL_RST;
            next_s.bias = BIAS_RST;
            next_s.mod = MOD_RST;
            next_s.bias_ceil = CEIL_RST;
            next_s.mod_ceil = CEIL_RST;
            next_s.fmask = FMASK_RST;
            next_s.deemph = DEEMPH_RST;
            next_s.eq = EQ_RST;
          end
        end else if (w_addr[4:0] == ADDR_BIAS[4:0]) begin
          next_s.bias = {(w_data > s.bias_ceil) ? s.bias_ceil : w_data,
                         s.bias[0]};
        end else if (w_addr[4:0] == ADDR_MOD[4:0]) begin
          next_s.mod = {(w_data > s.mod_ceil) ? s.mod_ceil : w_data,
                        s.mod[0]};
        end else if (w_addr[4:0] == ADDR_MOD_CEIL[4:0]) begin
          next_s.mod_ceil = w_data;
          // a lowered ceiling pulls the level down at once
          if (s.mod[8:1] > w_data) next_s.mod = {w_data, s.mod[0]};
        end else if (w_addr[4:0] == ADDR_BIAS_CEIL[4:0]) begin
          next_s.bias_ceil = w_data;
          if (s.bias[8:1] > w_data) next_s.bias = {w_data, s.bias[0]};
        end else if (w_addr[4:0] == ADDR_FMASK[4:0]) begin
          next_s.fmask = w_data;
        end else if (w_addr[4:0] == ADDR_DEEMPH[4:0]) begin
          next_s.deemph = w_data;
        end else if (w_addr[4:0] == ADDR_EQ[4:0]) begin
          next_s.eq = w_data[1:0];
        end
      end
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      s <= '0;
      s.tx_ctrl <= TX_CTRL_RST;
      s.bias <= BIAS_RST;
      s.mod <= MOD_RST;
      s.bias_ceil <= CEIL_RST;
      s.mod_ceil <= CEIL_RST;
      s.fmask <= FMASK_RST;
      s.deemph <= DEEMPH_RST;
      s.eq <= EQ_RST;
    end else begin
      s <= next_s;
    end
  end

  // address climbs one place per edge as data shifts in behind it
  logic [6:0] r_addr;
  logic rd_sel;
  always_comb begin
    r_addr = 7'h00;
    if (lk.cnt >= ADDR_BITS) r_addr = lk.sh[lk.cnt - 5'h01 -: 7];
    rd_sel = r_addr[6:5] == s.sel;
    if (r_addr[4:0] == ADDR_TX_CTRL[4:0]) rd_hold = s.tx_ctrl;
    else if (r_addr[4:0] == ADDR_HARD_ST[4:0]) rd_hold = s.hard_st;
    else if (r_addr[4:0] == ADDR_SOFT_ST[4:0]) rd_hold = s.soft_st;
    else if (r_addr[4:0] == ADDR_BIAS[4:0]) rd_hold = s.bias[8:1];
    else if (r_addr[4:0] == ADDR_MOD[4:0]) rd_hold = s.mod[8:1];
    else if (r_addr[4:0] == ADDR_MOD_CEIL[4:0]) rd_hold = s.mod_ceil;
    else if (r_addr[4:0] == ADDR_BIAS_CEIL[4:0]) rd_hold = s.bias_ceil;
    else if (r_addr[4:0] == ADDR_FMASK[4:0]) rd_hold = s.fmask;
    else if (r_addr[4:0] == ADDR_DEEMPH[4:0]) rd_hold = s.deemph;
    else if (r_addr[4:0] == ADDR_EQ[4:0]) rd_hold = {6'h00, s.eq};
    else rd_hold = 8'h00;
  end

  // read data leaves on the falling edge after the rnw bit; registers
  // are read across domains, so a status bit moving mid-read may tear
  always_comb begin
    next_rd = rd;
    if (lk.cnt == ADDR_BITS && lk.sh[0] && rd_sel) begin
      next_rd.drv = 1'b1;
      next_rd.bit_out = rd_hold[7];
      next_rd.idx = 3'h6;
    end else if (rd.drv && lk.cnt > ADDR_BITS) begin
      next_rd.bit_out = rd_hold[rd.idx];
      next_rd.idx = rd.idx - 3'h1;
    end
  end
  always_ff @(negedge ser_clk or negedge cs_n_rst) begin
    if (!cs_n_rst) begin
      rd <= '0;
    end else begin
      rd <= next_rd;
    end
  end
  assign sda_oe_n = ~rd.drv;
  assign sda_out = rd.bit_out;

  assign fault_out = s.fault;
  assign drive_enable = s.tx_ctrl[TXEN_BIT] && !s.dsync[1] &&
                        !s.fault;
  assign invert_path = ~s.tx_ctrl[POL_BIT];
  assign input_eq_setting = s.eq;
  assign deemph_mode = s.tx_ctrl[DEM_LO+1:DEM_LO];
  assign deemph_level = s.deemph;
  assign bias_level = s.bias;
  assign mod_level = s.mod;

  bias_ceil_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    s.bias[8:1] <= s.bias_ceil)
    else $error("bias above ceiling");
  mod_ceil_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    s.mod[8:1] <= s.mod_ceil)
    else $error("mod above ceiling");
  fault_drv_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    fault_out |-> !drive_enable)
    else $error("drive with fault");
  fault_set_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    |(s.hsync & ~s.fmask) |=> fault_out)
    else $error("fault not latched");
  fault_hold_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    fault_out && s.shut_d == s.dsync[1] |=> fault_out)
    else $error("fault dropped");
  sigdet_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    ##1 s.hard_st[SIGDET_BIT] == $past(s.ssync[1]))
    else $error("signal bit wrong");
  pol_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    invert_path == !s.tx_ctrl[POL_BIT])
    else $error("polarity wrong");
  txen_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    !s.tx_ctrl[TXEN_BIT] |-> !drive_enable)
    else $error("drive while disabled");
endmodule
`default_nettype wire
